/* File: pkg/flash_host_map.svh */
// flash host controller constants: register offsets, fields, opcodes, timing
// assumes: included by bare name from package and design files
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_WDATA 12'h008
`define REG_RDATA 12'h00C
`define REG_STAT 12'h010
`define REG_LEN 12'h014

// ---------------------------------------------------------------
// control and status fields
// ---------------------------------------------------------------
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 7
`define CTRL_START 8
`define CTRL_LONG_DUMMY 9
`define CTRL_HW_RESET 10
`define CTRL_QUAD_CMD 11
`define CTRL_MODE3 12
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_QCM 2
`define STAT_REJECT 3

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_DUAL_OUT 8'h3B
`define OP_DUAL_IO 8'hBB
`define OP_QUAD_OUT 8'h6B
`define OP_QUAD_IO 8'hEB
`define OP_QUAD_WORD 8'hE7
`define OP_SECTOR_ERASE 8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_FULL_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_PAGE_WRITE 8'h02
`define OP_QUAD_PAGE_WRITE 8'h32
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_VOLATILE_WE 8'h50
`define OP_BLOCK_LOCK 8'h36
`define OP_BLOCK_UNLOCK 8'h39
`define OP_LOCK_STATUS 8'h3D
`define OP_GLOBAL_LOCK 8'h7E
`define OP_GLOBAL_UNLOCK 8'h98
`define OP_SEC_ERASE 8'h44
`define OP_SEC_WRITE 8'h42
`define OP_SEC_READ 8'h48
`define OP_CLEAR_ARM 8'h66
`define OP_CLEAR_GO 8'h99
`define OP_QCM_ENTER 8'h38
`define OP_QCM_EXIT 8'hFF
`define OP_STATUS_READ 8'h05

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define RECOVERY_US 30
`define RECOVERY_CYC ((`RECOVERY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_CLEAR_PULSE_MIN_US 1
`define EXT_CLEAR_CYC ((`EXT_CLEAR_PULSE_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_DIV 4'h4

`endif

/* File: pkg/flash_host_pkg.sv */
// flash host controller types
// assumes: map header on include path
`include "flash_host_map.svh"
package flash_host_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_OPCODE = 4'b0001,
        ST_ADDR = 4'b0011,
        ST_DUMMY = 4'b0010,
        ST_DATA = 4'b0110,
        ST_DESELECT = 4'b0111,
        ST_RECOVER = 4'b0101,
        ST_HWRESET = 4'b0100
    } host_state_t;
    typedef enum logic [1:0] {
        LANES_1 = 2'b00,
        LANES_2 = 2'b01,
        LANES_4 = 2'b10
    } lanes_t;
endpackage : flash_host_pkg

/* File: src/sclk_divider.sv */
// serial clock divider: toggles sclk, flags rise and fall edges
// assumes: run high only while a frame is active
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"
module sclk_divider
    import flash_host_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic idle_high,
    output logic sclk,
    output logic rise,
    output logic fall
);
    logic [3:0] count;
    logic tick;
    assign tick = run && (count == `SCLK_HALF_DIV - 4'h1);
    assign rise = tick && (sclk == 1'b0);
    assign fall = tick && (sclk == 1'b1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= 4'h0;
        end else if (!run || tick) begin
            count <= 4'h0;
        end else begin
            count <= count + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk <= 1'b0;
        end else if (tick) begin
            sclk <= ~sclk;
        end else if (!run) begin
            sclk <= idle_high;
        end
    end
endmodule : sclk_divider
`default_nettype wire

/* File: src/flash_host_ctrl.sv */
// host controller for a serial nor flash, apb slave for software
// assumes: device pins joined by the bench; io pins resolved from enables
//
// Behaviour
// RL1: software polls status before next command
// RL2: host treats unknown opcode as no response
// RL3: drive on falling edge, sample on rising
// RL4: clock idles low (mode 0) or high (mode 3)
// RL5: reads may end after any output bit
// RL6: write-type commands end on byte boundary
// RL7: host blocks array access while busy
// RL8: 3Bh dual out, BBh dual io with dummies
// RL9: 6Bh quad out, EBh quad io with dummies
// RL10: 38h enters quad command mode, FFh leaves
// RL11: reset returns host to serial mode
// RL12: opcode on rising edges only
// RL13: soft reset is 66h then 99h
// RL14: wait 30us after soft reset
// RL15: reset pin low at least 1us
// RL16: 03h no dummies, 0Bh eight dummies
// RL17: E7h three address, four dummies
// RL18: erases take address, chip erase none
// RL19: program takes address and data bytes
// RL20: latch and volatile enables take nothing
// RL21: block lock commands take address
// RL22: security read has eight dummies
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"
module flash_host_ctrl
    import flash_host_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cs_n,
    output logic sclk,
    output logic reset_n,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic [3:0] io_in
);
    host_state_t state;
    lanes_t lanes;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [7:0] len;
    logic long_dummy, mode3, qcm, done, reject, armed, write_busy;
    logic [31:0] shreg;
    logic [5:0] bits_left;
    logic [7:0] bytes_left;
    logic [9:0] wait_cnt;
    logic [3:0] io_s1, io_s2, io_s3;
    logic sck_rise, sck_fall, run;
    logic is_read, has_addr, has_data, is_dual, is_quad, is_array;
    logic [4:0] dummy_cyc;
    logic access, wr_acc, start;

    assign access = psel && penable;
    assign wr_acc = access && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign start = wr_acc && (paddr == `REG_CTRL) && pwdata[`CTRL_START];

    // ---------------------------------------------------------------
    // opcode decode
    // ---------------------------------------------------------------
    always_comb begin
        is_read = 1'b0;
        has_addr = 1'b0;
        has_data = 1'b0;
        is_dual = 1'b0;
        is_quad = 1'b0;
        dummy_cyc = 5'd0;
        case (opcode)
            `OP_READ: begin is_read = 1'b1; has_addr = 1'b1; end // [RL16]
            `OP_FAST_READ, `OP_SEC_READ: begin // [RL16] [RL22]
                is_read = 1'b1; has_addr = 1'b1; dummy_cyc = 5'd8;
            end
            `OP_DUAL_OUT: begin is_read = 1'b1; has_addr = 1'b1; dummy_cyc = 5'd8; end // [RL8]
            `OP_DUAL_IO: begin // [RL8]
                is_read = 1'b1; has_addr = 1'b1; is_dual = 1'b1;
                dummy_cyc = long_dummy ? 5'd8 : 5'd4;
            end
            `OP_QUAD_OUT: begin is_read = 1'b1; has_addr = 1'b1; dummy_cyc = 5'd8; end // [RL9]
            `OP_QUAD_IO: begin // [RL9]
                is_read = 1'b1; has_addr = 1'b1; is_quad = 1'b1;
                dummy_cyc = long_dummy ? 5'd10 : 5'd6;
            end
            `OP_QUAD_WORD: begin // [RL17]
                is_read = 1'b1; has_addr = 1'b1; is_quad = 1'b1; dummy_cyc = 5'd4;
            end
            `OP_LOCK_STATUS: begin is_read = 1'b1; has_addr = 1'b1; end // [RL21]
            `OP_STATUS_READ: is_read = 1'b1; // [RL1]
            `OP_SECTOR_ERASE, `OP_HALF_BLOCK_ERASE, `OP_FULL_BLOCK_ERASE,
            `OP_BLOCK_LOCK, `OP_BLOCK_UNLOCK, `OP_SEC_ERASE: has_addr = 1'b1; // [RL18] [RL21]
            `OP_PAGE_WRITE, `OP_QUAD_PAGE_WRITE, `OP_SEC_WRITE: begin // [RL19] [RL22]
                has_addr = 1'b1; has_data = 1'b1;
            end
            default: ; // [RL20] opcode only
        endcase
    end
    assign is_array = has_addr && (opcode != `OP_LOCK_STATUS);

    // ---------------------------------------------------------------
    // apb registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            opcode <= 8'h00;
            long_dummy <= 1'b0;
            mode3 <= 1'b0;
            addr <= 24'h00_0000;
            wdata <= 32'h0000_0000;
            len <= 8'h01;
        end else if (wr_acc && state == ST_IDLE) begin
            if (paddr == `REG_CTRL) begin
                opcode <= pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
                long_dummy <= pwdata[`CTRL_LONG_DUMMY];
                mode3 <= pwdata[`CTRL_MODE3];
            end else if (paddr == `REG_ADDR) begin
                addr <= pwdata[23:0];
            end else if (paddr == `REG_WDATA) begin
                wdata <= pwdata;
            end else if (paddr == `REG_LEN) begin
                len <= pwdata[7:0];
            end
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == `REG_CTRL) begin
            prdata = {19'h0_0000, mode3, qcm, 1'b0, long_dummy, 1'b0, opcode};
        end else if (paddr == `REG_ADDR) begin
            prdata = {8'h00, addr};
        end else if (paddr == `REG_WDATA) begin
            prdata = wdata;
        end else if (paddr == `REG_RDATA) begin
            prdata = rdata;
        end else if (paddr == `REG_STAT) begin
            prdata = {27'h000_0000, write_busy, reject, qcm, done, state != ST_IDLE};
        end else if (paddr == `REG_LEN) begin
            prdata = {24'h00_0000, len};
        end
    end

    // ---------------------------------------------------------------
    // io input sync, three flops, last flop sampled
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
            io_s3 <= 4'h0;
        end else begin
            io_s1 <= io_in;
            io_s2 <= io_s1;
            io_s3 <= io_s2;
        end
    end

    assign run = (state == ST_OPCODE) || (state == ST_ADDR) || (state == ST_DUMMY)
        || (state == ST_DATA);

    sclk_divider u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(run),
        .idle_high(mode3), // [RL4]
        .sclk(sclk),
        .rise(sck_rise),
        .fall(sck_fall)
    );

    function automatic logic [5:0] step(input lanes_t l);
        step = (l == LANES_4) ? 6'd4 : (l == LANES_2) ? 6'd2 : 6'd1;
    endfunction : step

    // ---------------------------------------------------------------
    // frame sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cs_n <= 1'b1;
            reset_n <= 1'b1;
            lanes <= LANES_1;
            shreg <= 32'h0000_0000;
            bits_left <= 6'd0;
            bytes_left <= 8'h00;
            wait_cnt <= 10'd0;
            rdata <= 32'h0000_0000;
            qcm <= 1'b0;
            done <= 1'b0;
            reject <= 1'b0;
            armed <= 1'b0;
            write_busy <= 1'b0;
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    io_oe <= 4'h0;
                    if (wr_acc && paddr == `REG_CTRL && pwdata[`CTRL_HW_RESET]) begin
                        reset_n <= 1'b0; // [RL15]
                        wait_cnt <= 10'(`EXT_CLEAR_CYC);
                        state <= ST_HWRESET;
                        done <= 1'b0;
                    end else if (start) begin
                        done <= 1'b0;
                        reject <= 1'b0;
                        if (write_busy && pwdata[7:0] != `OP_STATUS_READ
                            && pwdata[7:0] != `OP_SUSPEND) begin
                            reject <= 1'b1; // [RL7] [RL1]
                            done <= 1'b1;
                        end else begin
                            cs_n <= 1'b0;
                            lanes <= qcm ? LANES_4 : LANES_1; // [RL10]
                            shreg <= {pwdata[7:0], 24'h00_0000};
                            bits_left <= 6'd8;
                            state <= ST_OPCODE;
                        end
                    end
                end
                ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA: begin
                    if (sck_fall || (state == ST_OPCODE && bits_left == 6'd8 && !sclk
                        && io_oe == 4'h0)) begin
                        // drive next lanes while sclk low [RL3]
                        if (!(state == ST_DATA && is_read) && state != ST_DUMMY) begin
                            io_oe <= (lanes == LANES_4) ? 4'hF : (lanes == LANES_2) ? 4'h3 : 4'h1;
                            io_out <= (lanes == LANES_4) ? shreg[31:28]
                                : (lanes == LANES_2) ? {2'b00, shreg[31:30]}
                                : {3'b000, shreg[31]};
                        end else begin
                            io_oe <= 4'h0;
                        end
                    end
                    if (sck_rise) begin // [RL3] [RL12]
                        if (state == ST_DATA && is_read) begin
                            shreg <= (lanes == LANES_4) ? {shreg[27:0], io_s3}
                                : (lanes == LANES_2) ? {shreg[29:0], io_s3[1:0]}
                                : {shreg[30:0], io_s3[1]};
                        end else begin
                            shreg <= shreg << step(lanes);
                        end
                        bits_left <= bits_left - ((state == ST_DUMMY) ? 6'd1 : step(lanes));
                        if (bits_left == ((state == ST_DUMMY) ? 6'd1 : step(lanes))) begin
                            case (state)
                                ST_OPCODE: begin
                                    if (has_addr) begin
                                        state <= ST_ADDR;
                                        shreg <= {addr, 8'h00};
                                        bits_left <= 6'd24;
                                        if (is_dual) lanes <= LANES_2; // [RL8]
                                        if (is_quad) lanes <= LANES_4; // [RL9]
                                    end else if (is_read) begin
                                        state <= ST_DATA;
                                        bits_left <= 6'd8;
                                        bytes_left <= len;
                                    end else begin
                                        state <= ST_DESELECT; // [RL6] [RL20]
                                    end
                                end
                                ST_ADDR: begin
                                    if (dummy_cyc != 5'd0) begin
                                        state <= ST_DUMMY;
                                        bits_left <= {1'b0, dummy_cyc};
                                    end else begin
                                        state <= (is_read || has_data) ? ST_DATA : ST_DESELECT;
                                        bits_left <= 6'd8;
                                        bytes_left <= len;
                                        shreg <= wdata;
                                        if (opcode == `OP_QUAD_PAGE_WRITE) lanes <= LANES_4; // [RL19]
                                    end
                                end
                                ST_DUMMY: begin
                                    state <= ST_DATA;
                                    bits_left <= 6'd8;
                                    bytes_left <= len;
                                    if (opcode == `OP_DUAL_OUT) lanes <= LANES_2;
                                    if (opcode == `OP_QUAD_OUT) lanes <= LANES_4;
                                end
                                default: begin
                                    bits_left <= 6'd8;
                                    bytes_left <= bytes_left - 8'h01;
                                    // write data: next byte already shifted to the top
                                    if (is_read) begin
                                        if (lanes == LANES_4) begin
                                            rdata <= {rdata[23:0], shreg[3:0], io_s3};
                                        end else if (lanes == LANES_2) begin
                                            rdata <= {rdata[23:0], shreg[5:0], io_s3[1:0]};
                                        end else begin
                                            rdata <= {rdata[23:0], shreg[6:0], io_s3[1]};
                                        end
                                    end
                                    if (bytes_left == 8'h01) state <= ST_DESELECT; // [RL5] [RL6]
                                end
                            endcase
                        end
                    end
                end
                ST_DESELECT: begin
                    cs_n <= 1'b1;
                    io_oe <= 4'h0;
                    lanes <= LANES_1;
                    done <= 1'b1;
                    armed <= (opcode == `OP_CLEAR_ARM); // [RL13]
                    if (opcode == `OP_QCM_ENTER) qcm <= 1'b1; // [RL10]
                    if (opcode == `OP_QCM_EXIT) qcm <= 1'b0; // [RL10]
                    if ((is_array && !is_read) || opcode == `OP_CHIP_ERASE_A
                        || opcode == `OP_CHIP_ERASE_B) write_busy <= 1'b1; // [RL7]
                    if (opcode == `OP_STATUS_READ && !rdata[0]) write_busy <= 1'b0;
                    if (opcode == `OP_CLEAR_GO && armed) begin
                        qcm <= 1'b0; // [RL11] [RL13]
                        write_busy <= 1'b0;
                        wait_cnt <= 10'(`RECOVERY_CYC);
                        state <= ST_RECOVER;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_RECOVER: begin
                    wait_cnt <= wait_cnt - 10'd1; // [RL14]
                    if (wait_cnt == 10'd1) state <= ST_IDLE;
                end
                default: begin
                    wait_cnt <= wait_cnt - 10'd1;
                    if (wait_cnt == 10'd1) begin
                        reset_n <= 1'b1; // [RL15]
                        qcm <= 1'b0; // [RL11]
                        armed <= 1'b0;
                        write_busy <= 1'b0;
                        done <= 1'b1;
                        state <= ST_RECOVER;
                        wait_cnt <= 10'(`RECOVERY_CYC);
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    recover_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL14]
        $rose(state == ST_RECOVER) |-> (state == ST_RECOVER)[*8])
        else $error("recovery ended early");
    hw_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL15]
        $fell(reset_n) |-> !reset_n[*8] ##1 !reset_n[*2])
        else $error("reset pulse too short");
    cs_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL6]
        state == ST_IDLE |-> cs_n)
        else $error("chip select low in idle");
    sclk_park_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL4]
        (state == ST_IDLE && !run && $past(state) == ST_IDLE) |-> sclk == $past(mode3))
        else $error("clock not parked");
    drive_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL3]
        $changed(io_out) && !cs_n |-> !sclk)
        else $error("io changed while clock high");
    busy_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
        (state == ST_IDLE && start && write_busy && pwdata[7:0] == `OP_READ) |=> reject && cs_n)
        else $error("array access while busy");
    qcm_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
        $rose(state == ST_RECOVER) |-> !qcm)
        else $error("quad command mode kept");
    quad_lanes_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL10]
        (state == ST_OPCODE && qcm) |-> lanes == LANES_4)
        else $error("opcode not on four lanes");
    read_c: cover property (@(posedge clk_sys) state == ST_DATA && is_read);
    write_c: cover property (@(posedge clk_sys) state == ST_DATA && has_data);
    soft_reset_c: cover property (@(posedge clk_sys) state == ST_RECOVER);
endmodule : flash_host_ctrl
`default_nettype wire

/* File: verif/flash_dev_model.sv */
// stand-in flash device: answers status and plain reads on lane 1
// assumes: bench resolves the io lanes and feeds them back as io
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] io,
    output logic [3:0] dev_out,
    output logic [3:0] dev_oe
);
    logic [7:0] op = 8'h00;
    logic [23:0] adr;
    logic [7:0] sh;
    int bits = 0;
    int p;
    initial begin
        dev_oe = 4'h0;
        dev_out = 4'h0;
    end
    always @(posedge cs_n) begin
        bits = 0;
        op = 8'h00;
        dev_oe = 4'h0;
    end
    always @(posedge sclk) begin
        if (!cs_n) begin
            if (bits < 8) op = {op[6:0], io[0]};
            else if (bits < 32) adr = {adr[22:0], io[0]};
            bits++;
        end
    end
    always @(negedge sclk) begin
        p = bits - ((op == 8'h03) ? 32 : 8);
        if (!cs_n && (op == 8'h05 || op == 8'h03) && p >= 0) begin
            if (p % 8 == 0) sh = (op == 8'h03) ? adr[7:0] + 8'(p / 8) : 8'h00;
            dev_out = {2'h0, sh[7], 1'b0};
            sh = sh << 1;
            dev_oe = 4'h2;
        end else begin
            dev_oe = 4'h0;
        end
    end
endmodule : flash_dev_model
`default_nettype wire

/* File: verif/flash_host_ctrl_tb_top.sv */
// bench for the flash host controller: apb orders, frame clocks, replies
// assumes: flash_dev_model answers status and plain reads on lane 1
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"
module flash_host_ctrl_tb_top;
    logic clk_sys = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, flip = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, q, prdata;
    logic pready, pslverr, cs_n, sclk, reset_n;
    logic [3:0] io_out, io_oe, io_in, dev_out, dev_oe;
    int bad_count = 0, checks_done = 0, rises = 0, lowc = 0, waited;
    logic [7:0] ops [25] = '{8'h06, 8'h04, 8'h50, 8'h7E, 8'h98, 8'h20, 8'h52, 8'hD8, 8'h60,
        8'hC7, 8'h36, 8'h39, 8'h44, 8'h75, 8'h7A, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hE7, 8'h48,
        8'h02, 8'h32, 8'h42, 8'h03};
    int nr [25] = '{8, 8, 8, 8, 8, 32, 32, 32, 8, 8, 32, 32, 32, 8, 8, 44, 42, 28, 22, 20, 48,
        40, 34, 40, 40};
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) flip <= ~flip;
    always @(posedge clk_sys) if (!reset_n) lowc++;
    always @(posedge sclk) if (!cs_n) rises++;
    always @(negedge cs_n) rises = 0;
    assign io_in = (io_oe & io_out) | (~io_oe & dev_oe & dev_out) | (~io_oe & ~dev_oe & {4{flip}});
    flash_host_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .reset_n(reset_n), .io_out(io_out),
        .io_oe(io_oe), .io_in(io_in));
    flash_dev_model model (.cs_n(cs_n), .sclk(sclk), .io(io_in), .dev_out(dev_out),
        .dev_oe(dev_oe));
    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 99);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 99) begin
            bad_count++;
            report_and_stop();
        end
    endtask : apb
    // start a command, poll until idle, compare clocks in the frame
    task cmd(input logic [31:0] ctrl, input int er);
        rises = 0;
        apb(1'b1, `REG_CTRL, ctrl);
        waited = 0;
        do begin
            apb(1'b0, `REG_STAT, '0);
            waited++;
        end while (q[0] !== 1'b0 && waited < 999);
        if (waited >= 999) begin
            bad_count++;
            report_and_stop();
        end
        chk(rises, er);
    endtask : cmd
    task t_idle;
        chk({cs_n, reset_n, io_oe}, 6'h30);
        chk({pready, pslverr}, 2'b10);
        apb(1'b0, 12'h020, '0);
        chk(q, '0);
        apb(1'b0, `REG_STAT, '0);
        chk(q[2:0], 3'h0);
    endtask : t_idle
    task t_read;
        apb(1'b1, `REG_ADDR, 32'h0000_0123);
        apb(1'b1, `REG_LEN, 32'h0000_0002);
        cmd(32'h0000_0103, 48);
        apb(1'b0, `REG_RDATA, '0);
        chk(q[15:0], 16'h2324);
        cmd(32'h0000_010B, 56);
        apb(1'b1, `REG_LEN, 32'h0000_0001);
    endtask : t_read
    task t_table;
        for (int i = 0; i < 25; i++) begin
            cmd({23'h0, 1'b1, ops[i]}, nr[i]);
            cmd(32'h0000_0105, 16);
        end
    endtask : t_table
    task t_busy;
        cmd(32'h0000_0120, 32);
        cmd(32'h0000_0103, 0);
        chk(q[3], 1'b1);
        cmd(32'h0000_0105, 16);
        cmd(32'h0000_0103, 40);
    endtask : t_busy
    task t_modes;
        apb(1'b1, `REG_CTRL, 32'h0000_1006);
        apb(1'b0, `REG_CTRL, '0);
        chk(q, 32'h0000_1006);
        cmd(32'h0000_1106, 8);
        chk(sclk, 1'b1);
        cmd(32'h0000_0106, 8);
        chk(sclk, 1'b0);
        cmd(32'h0000_0138, 8);
        chk(q[2], 1'b1);
        cmd(32'h0000_01FF, 2);
        chk(q[2], 1'b0);
        cmd(32'h0000_0138, 8);
        cmd(32'h0000_0166, 2);
        cmd(32'h0000_0199, 2);
        chk(waited > 99, 1'b1);
        chk(q[2], 1'b0);
        lowc = 0;
        cmd(32'h0000_0400, 0);
        chk(lowc > 9, 1'b1);
    endtask : t_modes
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_idle();
        t_read();
        t_table();
        t_busy();
        t_modes();
        report_and_stop();
    end
endmodule : flash_host_ctrl_tb_top
`default_nettype wire
